// [src/can_safety_core.sv]
// CAN controller safety logic: loopback, ECC message RAM, timeout, timestamp
`timescale 1ns/1ps

// Functional notes
// - Loopback is active only while the loopback test bit and the bus monitor bit are both 1.
// - In loopback the receive pin is ignored, transmit feeds receive, and the transmit pin stays recessive.
// - Every message RAM write stores ECC check bits and every read corrects single-bit errors.
// - All ECC error status is combined into one interrupt line.
// - Software reads single or double error flags, the failing address and the error bit position.
// - Software can configure ECC reporting and inject errors into the read data path.
// - Injected errors are reported through the same flags and interrupt as natural ones.
// - In continuous mode a write of the preset reloads the counter, and software rewrites it before expiry.
// - In a FIFO mode an empty FIFO presets the counter and the first push starts the down-count.
// - Received and transmitted messages get a timestamp from the internal counter, or from the external timestamp input for FD messages.
// - The timestamp counter advances through a programmable prescaler.
// - Each sent or received message has the current timestamp written into its buffer entry.
module can_safety_core #(
  parameter int DATA_W = can_safety_pkg::DATA_W_DEF,
  parameter int ADDR_W = can_safety_pkg::ADDR_W_DEF,
  parameter int TO_W = can_safety_pkg::TO_W_DEF,
  parameter int TS_W = can_safety_pkg::TS_W_DEF,
  parameter int PSC_W = can_safety_pkg::PSC_W_DEF,
  parameter int SLOT_W = can_safety_pkg::SLOT_W_DEF,
  localparam int P = can_safety_pkg::hammingBits(DATA_W),
  localparam int CW = DATA_W + P + 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Loopback control and pins
  input wire logic loopbackTestBit,
  input wire logic busMonitorBit,
  input wire logic txBit,
  input wire logic rxPin,
  output logic txPin,
  output logic coreRx,
  // Message RAM
  input wire logic memWrite,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic memRead,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  // ECC aggregator
  input wire logic injEnable,
  input wire logic [CW-1:0] injMask,
  input wire logic eccIntEnable,
  input wire logic eccClear,
  output logic eccSingle,
  output logic eccDouble,
  output logic [ADDR_W-1:0] errAddr,
  output logic [P-1:0] errBitPos,
  output logic eccIrq,
  // Timeout counter
  input wire logic timeoutEnable,
  input wire logic [1:0] timeoutMode,
  input wire logic presetWrite,
  input wire logic [TO_W-1:0] timeoutPreset,
  input wire logic [2:0] fifoEmpty,
  input wire logic [2:0] fifoPush,
  input wire logic timeoutIntEnable,
  input wire logic timeoutClear,
  output logic [TO_W-1:0] timeoutCount,
  output logic timeoutFlag,
  output logic timeoutIrq,
  // Timestamp
  input wire logic [PSC_W-1:0] tsPrescale,
  input wire logic msgDone,
  input wire logic msgIsFd,
  input wire logic [SLOT_W-1:0] msgSlot,
  input wire logic [TS_W-1:0] extTimestamp,
  input wire logic [SLOT_W-1:0] tsRdSlot,
  output logic [TS_W-1:0] timestampCount,
  output logic [TS_W-1:0] tsRdData
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int SLOTS = 1 << SLOT_W;

  typedef struct packed {
    logic txPin;
    logic coreRx;
    logic [DEPTH-1:0][CW-1:0] mem;
    logic [DATA_W-1:0] rdData;
    logic rdValid;
    logic eccSingle;
    logic eccDouble;
    logic [ADDR_W-1:0] errAddr;
    logic [P-1:0] errBitPos;
    logic eccIrq;
    logic [TO_W-1:0] toCount;
    logic toRun;
    logic toFlag;
    logic toIrq;
    logic [PSC_W-1:0] psc;
    logic [TS_W-1:0] ts;
    logic [SLOTS-1:0][TS_W-1:0] tsMem;
    logic [TS_W-1:0] tsRdData;
  } state_s;

  state_s state;
  state_s next_state;

  //////////////////////////////////////////////////////////////////////////////
  // ECC code: position 0 holds overall parity, powers of two hold check bits
  function automatic logic [CW-1:0] eccEncode(input logic [DATA_W-1:0] d);
    logic [CW-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    end
    for (int p = 0; p < P; p++) begin
      for (int i = 1; i < CW; i++) begin
        if (i[p] && i != (1 << p)) c[1 << p] = c[1 << p] ^ c[i];
      end
    end
    c[0] = ^c[CW-1:1];
    return c;
  endfunction

  function automatic logic [P-1:0] eccSyndrome(input logic [CW-1:0] c);
    logic [P-1:0] s;
    s = '0;
    for (int i = 1; i < CW; i++) begin
      if (c[i]) s = s ^ P'(i);
    end
    return s;
  endfunction

  function automatic logic [DATA_W-1:0] eccData(input logic [CW-1:0] c);
    logic [DATA_W-1:0] d;
    int k;
    d = '0;
    k = 0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = c[i];
        k++;
      end
    end
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic loopMode;
    logic [CW-1:0] raw;
    logic [P-1:0] syn;
    logic parOdd;
    logic isSingle;
    logic isDouble;
    logic fifoMode;
    logic [1:0] fi;
    logic expire;
    logic tick;
    loopMode = 1'b0;
    raw = '0;
    syn = '0;
    parOdd = 1'b0;
    isSingle = 1'b0;
    isDouble = 1'b0;
    fifoMode = 1'b0;
    fi = '0;
    expire = 1'b0;
    tick = 1'b0;
    next_state = state;

    // Loopback
    loopMode = loopbackTestBit & busMonitorBit;
    next_state.txPin = loopMode ? can_safety_pkg::TX_RECESSIVE : txBit;
    next_state.coreRx = loopMode ? txBit : rxPin;

    // Message RAM with error injection on the read path
    if (memWrite) begin
      next_state.mem[wrAddr] = eccEncode(wrData);
    end
    raw = state.mem[rdAddr] ^ (injEnable ? injMask : '0);
    syn = eccSyndrome(raw);
    parOdd = ^raw;
    isSingle = memRead & parOdd;
    isDouble = memRead & ~parOdd & (syn != '0);
    next_state.rdValid = memRead;
    if (memRead) begin
      next_state.rdData = eccData(parOdd ? raw ^ (CW'(1) << syn) : raw);
    end

    // Aggregator, a new error wins over a clear
    next_state.eccSingle = (state.eccSingle & ~eccClear) | isSingle;
    next_state.eccDouble = (state.eccDouble & ~eccClear) | isDouble;
    if (isSingle | isDouble) begin
      next_state.errAddr = rdAddr;
      next_state.errBitPos = syn;
    end
    next_state.eccIrq = eccIntEnable &
      (next_state.eccSingle | next_state.eccDouble);

    // Timeout counter
    fifoMode = can_safety_pkg::timeout_mode_e'(timeoutMode) !=
      can_safety_pkg::TO_CONTINUOUS;
    fi = timeoutMode - 2'h1;
    if (!timeoutEnable) begin
      next_state.toRun = 1'b0;
    end else if (!fifoMode && presetWrite) begin
      next_state.toCount = timeoutPreset;
      next_state.toRun = 1'b1;
    end else if (fifoMode && fifoEmpty[fi] && !fifoPush[fi]) begin
      next_state.toCount = timeoutPreset;
      next_state.toRun = 1'b0;
    end else if (fifoMode && fifoPush[fi] && !state.toRun &&
                 state.toCount != '0) begin
      next_state.toRun = 1'b1;
    end else if (state.toRun) begin
      if (state.toCount == '0) begin
        next_state.toRun = 1'b0;
        expire = 1'b1;
      end else begin
        next_state.toCount = state.toCount - TO_W'(1);
      end
    end
    next_state.toFlag = (state.toFlag & ~timeoutClear) | expire;
    next_state.toIrq = timeoutIntEnable & next_state.toFlag;

    // Timestamp counter and per-message capture
    tick = state.psc >= tsPrescale;
    next_state.psc = tick ? '0 : state.psc + PSC_W'(1);
    if (tick) begin
      next_state.ts = state.ts + TS_W'(1);
    end
    if (msgDone) begin
      next_state.tsMem[msgSlot] = msgIsFd ? extTimestamp :
        state.ts;
    end
    next_state.tsRdData = state.tsMem[tsRdSlot];
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= '0;
      state.txPin <= can_safety_pkg::TX_RESET;
      state.coreRx <= can_safety_pkg::RX_RESET;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign txPin = state.txPin;
  assign coreRx = state.coreRx;
  assign rdData = state.rdData;
  assign rdValid = state.rdValid;
  assign eccSingle = state.eccSingle;
  assign eccDouble = state.eccDouble;
  assign errAddr = state.errAddr;
  assign errBitPos = state.errBitPos;
  assign eccIrq = state.eccIrq;
  assign timeoutCount = state.toCount;
  assign timeoutFlag = state.toFlag;
  assign timeoutIrq = state.toIrq;
  assign timestampCount = state.ts;
  assign tsRdData = state.tsRdData;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic [DATA_W-1:0] storedData;
  assign storedData = eccData(state.mem[rdAddr]);
  loop_tx_a: assert property (
    (loopbackTestBit && busMonitorBit) |=> txPin == 1'b1
  ) else $error("Transmit pin not recessive in loopback");
  loop_rx_a: assert property (
    (loopbackTestBit && busMonitorBit) |=> coreRx == $past(txBit)
  ) else $error("Loopback receive does not follow transmit");
  no_loop_a: assert property (
    !(loopbackTestBit && busMonitorBit) |=> txPin == $past(txBit) &&
      coreRx == $past(rxPin)
  ) else $error("Loopback active without both control bits");
  single_fix_a: assert property (
    (memRead && injEnable && $onehot(injMask)) |=>
      eccSingle && rdData == $past(storedData)
  ) else $error("Single-bit error not corrected or not flagged");
  double_irq_a: assert property (
    (memRead && injEnable && $countones(injMask) == 2 && eccIntEnable) |=>
      eccDouble && eccIrq
  ) else $error("Injected double error not reported");
  err_addr_a: assert property (
    (memRead && injEnable && $onehot(injMask)) |=>
      errAddr == $past(rdAddr)
  ) else $error("Failing address not captured");
  cont_load_a: assert property (
    (timeoutEnable && timeoutMode == 2'h0 && presetWrite) |=>
      timeoutCount == $past(timeoutPreset)
  ) else $error("Continuous preset write did not reload");
  sequence emptyPreset;
    timeoutEnable && timeoutMode != 2'h0 && timeoutPreset != '0 &&
      fifoEmpty[timeoutMode - 2'h1] && !fifoPush[timeoutMode - 2'h1];
  endsequence
  sequence firstPush;
    timeoutEnable && $stable(timeoutMode) &&
      !fifoEmpty[timeoutMode - 2'h1] && fifoPush[timeoutMode - 2'h1];
  endsequence
  sequence keepRunning;
    timeoutEnable && $stable(timeoutMode) &&
      !fifoEmpty[timeoutMode - 2'h1];
  endsequence
  fifo_start_a: assert property (
    emptyPreset ##1 firstPush ##1 keepRunning |=>
      timeoutCount == $past(timeoutCount) - TO_W'(1)
  ) else $error("First push did not start the down-count");
  to_stop_a: assert property (
    $rose(timeoutFlag) |-> timeoutCount == '0 && $stable(timeoutCount)
  ) else $error("Timeout flag without counter at zero");
  ts_wrap_a: assert property (
    $changed(timestampCount) |->
      timestampCount == TS_W'($past(timestampCount) + TS_W'(1))
  ) else $error("Timestamp did not step by one");
  ts_scale_a: assert property (
    ($changed(timestampCount) && tsPrescale == PSC_W'(1)) |=>
      $stable(timestampCount)
  ) else $error("Timestamp ignores the prescaler");
  ts_store_a: assert property (
    (msgDone && !msgIsFd && tsRdSlot == msgSlot) ##1
      (!msgDone && $stable(tsRdSlot)) |=>
      tsRdData == $past(timestampCount, 2)
  ) else $error("Timestamp not stored in message entry");
endmodule // can_safety_core

// [src/can_safety_pkg.sv]
// Constants and types shared by the CAN safety block
package can_safety_pkg;

  // Transmit pin level that leaves the bus undisturbed
  localparam logic TX_RECESSIVE = 1'h1;
  // Values after reset
  localparam logic TX_RESET = TX_RECESSIVE;
  localparam logic RX_RESET = TX_RECESSIVE;

  // Default widths
  localparam int DATA_W_DEF = 32;
  localparam int ADDR_W_DEF = 6;
  localparam int TO_W_DEF = 16;
  localparam int TS_W_DEF = 16;
  localparam int PSC_W_DEF = 4;
  localparam int SLOT_W_DEF = 5;

  // Timeout counter source
  typedef enum logic [1:0] {
    TO_CONTINUOUS,
    TO_TX_FIFO,
    TO_RX0_FIFO,
    TO_RX1_FIFO
  } timeout_mode_e;

  // Check bits of a single-error-correcting Hamming code
  function automatic int hammingBits(input int dw);
    int p;
    p = 0;
    while ((1 << p) < dw + p + 1) p++;
    return p;
  endfunction

endpackage

// [tb/can_bus_model.sv]
// Behavioural CAN bus with one extra node behind a transceiver
`timescale 1ns/1ps
module can_bus_model (
  // Our node and the other node
  input wire logic txPin,
  input wire logic extBit,
  // Receive pin seen by our node
  output logic rxPin
);
  // Wired bus: dominant 0 wins, idle bus stays recessive
  assign rxPin = txPin & extBit;
endmodule // can_bus_model

// [tb/tb_can_safety_core.sv]
// Self-checking testbench of the CAN safety core
`timescale 1ns/1ps
module tb_can_safety_core;
  typedef struct {logic [31:0] d; logic s, b, full; logic [5:0] pos, a;} note_s;
  logic clock = 0, nrst = 0, loopbackTestBit = 0, busMonitorBit = 0;
  logic txBit = 1, extBit = 1, rxPin, txPin, coreRx, memWrite = 0;
  logic memRead = 0, rdValid, injEnable = 0, eccIntEnable = 1, eccClear = 0;
  logic [5:0] wrAddr = 0, rdAddr = 0, errAddr, errBitPos, a, lastErr;
  logic [31:0] wrData = 0, rdData, d;
  logic [38:0] injMask = 0;
  logic eccSingle, eccDouble, eccIrq, timeoutEnable = 0, presetWrite = 0;
  logic [1:0] timeoutMode = 0;
  logic [15:0] timeoutPreset = 0, timeoutCount, extTimestamp = 0, t0;
  logic [15:0] timestampCount, tsRdData;
  logic [2:0] fifoEmpty = 0, fifoPush = 0;
  logic timeoutIntEnable = 1, timeoutClear = 0, timeoutFlag, timeoutIrq;
  logic [3:0] tsPrescale = 0;
  logic msgDone = 0, msgIsFd = 0;
  logic [4:0] msgSlot = 0, tsRdSlot = 0;
  int miscompares = 0, checks = 0, k, m, n, p;
  note_s notes[$];
  note_s cur;

  can_safety_core dut_u (.clock, .nrst, .loopbackTestBit, .busMonitorBit,
    .txBit, .rxPin, .txPin, .coreRx, .memWrite, .wrAddr, .wrData, .memRead,
    .rdAddr, .rdData, .rdValid, .injEnable, .injMask, .eccIntEnable,
    .eccClear, .eccSingle, .eccDouble, .errAddr, .errBitPos, .eccIrq,
    .timeoutEnable, .timeoutMode, .presetWrite, .timeoutPreset, .fifoEmpty,
    .fifoPush, .timeoutIntEnable, .timeoutClear, .timeoutCount, .timeoutFlag,
    .timeoutIrq, .tsPrescale, .msgDone, .msgIsFd, .msgSlot, .extTimestamp,
    .tsRdSlot, .timestampCount, .tsRdData);
  can_bus_model bus_u (.txPin(txPin), .extBit(extBit), .rxPin(rxPin));

  initial begin
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c = 1);
    repeat (c) @(negedge clock);
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [5:0] ad, input logic [38:0] msk,
    input note_s nt);
    rdAddr = ad;
    injMask = msk;
    injEnable = |msk;
    memRead = 1;
    notes.push_back(nt);
    tick();
    memRead = 0;
    tick();
  endtask

  task automatic toClear;
    timeoutClear = 1;
    tick();
    timeoutClear = 0;
    check(timeoutFlag, 0);
  endtask

  // Read results land one cycle after the request
  always @(negedge clock) begin
    if (rdValid === 1'b1) begin
      cur = notes.pop_front();
      if (cur.full) check(rdData, cur.d);
      check({eccSingle, eccDouble, errAddr}, {cur.s, cur.b, cur.a});
      check(eccIrq, (cur.s | cur.b) & eccIntEnable);
      if (cur.s) check(errBitPos, cur.pos);
    end
  end

  initial begin
    #720000;
    miscompares++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81534));
    tick(20);
    nrst = 1;
    for (k = 0; k < 16; k++) begin
      {loopbackTestBit, busMonitorBit} = 2'(k);
      txBit = 1'($urandom);
      extBit = 1'($urandom);
      n = txPin & extBit;
      tick();
      if (k[1:0] == 3) check({txPin, coreRx}, {1'b1, txBit});
      else check({txPin, coreRx}, {txBit, n[0]});
    end
    lastErr = 0;
    for (k = 0; k < 4; k++) begin
      a = 6'($urandom);
      eccIntEnable = (k != 0);
      d = $urandom;
      n = $urandom_range(0, 38);
      m = n % 38 + 1;
      wrAddr = a;
      wrData = d;
      memWrite = 1;
      tick();
      memWrite = 0;
      rd(a, 0, '{d, 0, 0, 1, 0, lastErr});
      rd(a, 39'h1 << n, '{d, 1, 0, 1, 6'(n), a});
      eccClear = 1;
      tick();
      eccClear = 0;
      check({eccSingle, eccDouble, eccIrq}, 0);
      rd(a, (39'h1 << n) | (39'h1 << m), '{d, 0, 1, 0, 0, a});
      lastErr = a;
      eccClear = 1;
      tick();
      eccClear = 0;
    end
    timeoutEnable = 1;
    timeoutPreset = 16'h0004;
    presetWrite = 1;
    tick();
    presetWrite = 0;
    check(timeoutCount, 4);
    tick(2);
    check(timeoutCount, 2);
    presetWrite = 1;
    tick();
    presetWrite = 0;
    check(timeoutCount, 4);
    tick(4);
    check({timeoutCount, timeoutFlag}, 0);
    tick();
    check({timeoutFlag, timeoutIrq}, 2'b11);
    toClear();
    for (m = 1; m < 4; m++) begin
      n = $urandom_range(2, 9);
      timeoutMode = 2'(m);
      timeoutPreset = 16'(n);
      fifoEmpty[m-1] = 1;
      tick();
      fifoEmpty = 0;
      check(timeoutCount, n);
      fifoPush[m-1] = 1;
      tick();
      fifoPush = 0;
      tick(n - 1);
      check({timeoutCount, timeoutFlag}, 16'h0001 << 1);
      tick(2);
      check({timeoutCount, timeoutFlag}, 1);
      toClear();
    end
    for (k = 0; k < 3; k++) begin
      p = (k == 0) ? 1 : $urandom_range(0, 7);
      tsPrescale = 4'(p);
      tick(20);
      t0 = timestampCount;
      tick(3 * (p + 1));
      check(timestampCount, 16'(t0 + 3));
    end
    for (k = 0; k < 4; k++) begin
      msgSlot = 5'($urandom);
      tsRdSlot = msgSlot;
      msgIsFd = k[0];
      extTimestamp = 16'($urandom);
      msgDone = 1;
      t0 = msgIsFd ? extTimestamp : timestampCount;
      tick();
      msgDone = 0;
      tick();
      check(tsRdData, t0);
    end
    tsPrescale = 0;
    tick(4);
    t0 = timestampCount;
    tick(65536);
    check(timestampCount, t0);
    check(notes.size(), 0);
    results();
  end
endmodule // tb_can_safety_core
